// file: logic/can_control_error_status.v
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "can_ctrl_err_map.vh"

// Control and error-status registers of one CAN controller.
// The frame engine reports events as one-cycle pulses from the same clock.
// Since those pulses share the clock, they enter the logic with no
// synchroniser; a pulse from another clock domain would need one first.
// Software reaches the block through a plain register port. A write is one
// cycle with the write strobe, address and data. A read is one cycle with
// the read strobe and address, and its answer stands in the next cycle only.
// The slave never stalls, so back-to-back strobes are always accepted.
// The control register is written in halves. The upper byte holds set bits
// and the lower byte holds clear bits, so no read-modify-write is needed.
// A pair with both halves high or both low leaves its bit alone. This lets
// one write touch a single field while every other field keeps its value.
// The operating mode and the valid flag are read-only to software while power save is on.
// Software must return to no power save before it changes either of them.
// The retry bit has no such lock, as it only matters once a frame is sent.
// Stop mode is entered only from sleep and left only towards sleep.
// A write that jumps straight between none and stop has its power-save part dropped whole.
// Applying half of such a write could leave the prohibited code behind.
// The prohibited code itself is refused from every starting point.
// The last error code follows the frame engine; software may only zero it.
// A mode change never touches it, so the cause of a bus-off survives the
// return to initialization and stays readable for diagnosis.
// A new error that meets a zero write in one cycle wins over the write.
// The error counters are read-only to software. They follow the main
// fault-confinement steps only: eight per transmit error not flagged primary dominant, one or eight per
// receive error, one down per success, and a reload after receive passive.
// Rarer cases of the protocol, such as the exceptions on error flags, are
// left to the frame engine, which may simply not pulse the error input.
// The transmit counter is nine bits wide, so bus-off is a plain compare.
// It freezes once bus-off is reached until software clears it.
// The receive counter saturates at its top value rather than wrapping.
// The clear request can only be raised in initialization mode. It lives
// for one cycle, clears both counters if the mode is still initialization, and then drops by itself.
// A fresh request in the cycle the old one drops is kept, not lost.
// Every output is a flip-flop, so the mode outputs trail the registers by
// one cycle; logic downstream must allow for that lag.
// The lost-arbitration input is kept on the port for the frame engine's
// wiring, but the retry decision is fully given by the retry output.
// Read data are zero outside their answer cycle. That keeps a shared read
// bus quiet and makes a stray value easy to spot on a trace.
// Unmapped indices read zero and ignore writes, so a wrong address cannot
// disturb the state of the block.
// The transmit count view is invalid while bus-off holds;
// software must look at the level fields before it trusts a count.
// The transmit count shows only its low byte, so it wraps at bus-off.
// Reset clears every register and output, including the error state.
// After reset the block sits in initialization with no power save.
module can_control_error_status #(
    parameter ADDR_W = 4
) (
    input wire i_clock,
    input wire i_srst,
    input wire [ADDR_W-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_valid_frame,
    input wire i_err_valid,
    input wire [2:0] i_err_code,
    input wire i_tx_error,
    input wire i_tx_primary_dominant,
    input wire i_tx_success,
    input wire i_rx_error,
    input wire i_rx_primary,
    input wire i_rx_success,
    input wire i_lost_arbitration,
    output reg [15:0] o_rdata,
    output reg [2:0] o_operating_mode,
    output reg [1:0] o_power_save,
    output reg o_lost_arbitration_retry,
    output reg o_retry_after_loss,
    output reg o_bus_off_flag
);

    reg operating_sel_b0_q;
    reg operating_sel_b1_q;
    reg operating_sel_b2_q;
    reg power_save_sel_lo_q;
    reg power_save_sel_hi_q;
    reg lost_arbitration_retry_q;
    reg valid_flag_q;
    reg error_counter_clear_request_q;
    reg [2:0] last_error_code_q;
    reg [8:0] tx_error_count_q;
    reg [7:0] rx_error_count_q;
    reg [8:0] tx_next;
    reg [7:0] rx_next;
    reg [15:0] read_mux;
    // Decodes and packed views of the state.
    wire ctl_wr;
    wire lec_wr;
    wire [2:0] op_now;
    wire [1:0] ps_now;
    wire [1:0] ps_req;
    wire ps_ok;
    wire bus_off_flag;
    wire [1:0] tx_error_level;
    wire [1:0] rx_error_level;
    wire rx_passive_flag;
    wire [7:0] error_level_info;
    wire [15:0] error_counters;

    // Set/clear pair: set alone gives 1, clear alone gives 0, else hold.
    // Both halves high counts as no request rather than as a toggle.
    function set_clear;
        input cur;
        input set_bit;
        input clr_bit;
        begin
            case ({set_bit, clr_bit})
                `PAIR_SET: set_clear = 1'b1;
                `PAIR_CLR: set_clear = 1'b0;
                default: set_clear = cur;
            endcase
        end
    endfunction

    // Write strobe aimed at one register index.
    function write_to;
        input wr;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] target;
        begin
            write_to = wr && (addr == target);
        end
    endfunction

    // Error level of a counter against the warning and passive limits.
    function [1:0] level_of;
        input [8:0] count;
        begin
            if (count >= `PASSIVE_LIMIT) begin
                level_of = `LVL_PASSIVE;
            end else if (count >= `WARN_LIMIT) begin
                level_of = `LVL_WARN;
            end else begin
                level_of = `LVL_LOW;
            end
        end
    endfunction

    assign ctl_wr = write_to(i_wr, i_addr, `ADDR_MODULE_CONTROL);
    assign lec_wr = write_to(i_wr, i_addr, `ADDR_LAST_PROTOCOL_ERROR);
    assign op_now = {operating_sel_b2_q, operating_sel_b1_q, operating_sel_b0_q};
    assign ps_now = {power_save_sel_hi_q, power_save_sel_lo_q};

    // Power-save request after applying the pairs, used to screen stop transitions.
    assign ps_req = {
        set_clear(power_save_sel_hi_q, i_wdata[`CTL_PS_HI + `CTL_SET_SHIFT],
            i_wdata[`CTL_PS_HI]),
        set_clear(power_save_sel_lo_q, i_wdata[`CTL_PS_LO + `CTL_SET_SHIFT],
            i_wdata[`CTL_PS_LO])};
    // Power-save step screen: stop is reached and left only through sleep.
    // The prohibited code is refused from any starting point.
    function ps_allowed;
        input [1:0] cur;
        input [1:0] req;
        begin
            if (req == `PS_BAD) begin
                ps_allowed = 1'b0;
            end else begin
                case (cur)
                    `PS_NONE: ps_allowed = (req != `PS_STOP);
                    `PS_STOP: ps_allowed = (req != `PS_NONE);
                    default: ps_allowed = 1'b1;
                endcase
            end
        end
    endfunction

    // A jump between none and stop skips sleep, so it is dropped whole.
    assign ps_ok = ps_allowed(ps_now, ps_req);

    // Status views derived straight from the counters.
    // They are plain compares, so they follow a counter in the same cycle
    // and disagree with the count that software reads only once bus-off wraps the transmit low byte.
    assign bus_off_flag = (tx_error_count_q >= `BUSOFF_LIMIT);
    assign tx_error_level = level_of(tx_error_count_q);
    assign rx_error_level = level_of({1'b0, rx_error_count_q});
    assign rx_passive_flag = ({1'b0, rx_error_count_q} >= `PASSIVE_LIMIT);
    assign error_level_info = {3'h0, bus_off_flag, tx_error_level, rx_error_level};
    assign error_counters = {rx_passive_flag, rx_error_count_q[6:0],
        tx_error_count_q[7:0]};

    // Retry-after-loss bit; its pair works in every mode.
    always @(posedge i_clock) begin
        if (i_srst) begin
            lost_arbitration_retry_q <= 1'b0;
        end else if (ctl_wr) begin
            lost_arbitration_retry_q <= set_clear(lost_arbitration_retry_q,
                i_wdata[`CTL_SET_RETRY], i_wdata[`CTL_CLR_RETRY]);
        end
    end

    // Operating mode bits; they go read-only while sleeping or stopped.
    always @(posedge i_clock) begin
        if (i_srst) begin
            operating_sel_b0_q <= 1'b0;
            operating_sel_b1_q <= 1'b0;
            operating_sel_b2_q <= 1'b0;
        end else if (ctl_wr && (ps_now == `PS_NONE)) begin
            operating_sel_b0_q <= set_clear(operating_sel_b0_q,
                i_wdata[`CTL_OP_LO + `CTL_SET_SHIFT], i_wdata[`CTL_OP_LO]);
            operating_sel_b1_q <= set_clear(operating_sel_b1_q,
                i_wdata[`CTL_OP_LO + 1 + `CTL_SET_SHIFT], i_wdata[`CTL_OP_LO + 1]);
            operating_sel_b2_q <= set_clear(operating_sel_b2_q,
                i_wdata[`CTL_OP_HI + `CTL_SET_SHIFT], i_wdata[`CTL_OP_HI]);
        end
    end

    // Power-save bits; a screened request lands whole or not at all.
    always @(posedge i_clock) begin
        if (i_srst) begin
            power_save_sel_lo_q <= 1'b0;
            power_save_sel_hi_q <= 1'b0;
        end else if (ctl_wr && ps_ok) begin
            power_save_sel_lo_q <= ps_req[0];
            power_save_sel_hi_q <= ps_req[1];
        end
    end

    // Clear request; a new request beats the self-clear of an old one.
    always @(posedge i_clock) begin
        if (i_srst) begin
            error_counter_clear_request_q <= 1'b0;
        end else if (ctl_wr && i_wdata[`CTL_SET_CLEAR_REQ] && (op_now == `OP_INIT)) begin
            error_counter_clear_request_q <= 1'b1;
        end else if (error_counter_clear_request_q) begin
            error_counter_clear_request_q <= 1'b0;
        end
    end

    // Valid flag; a new frame wins over a clear in the same cycle.
    // Like the mode bits, it is read-only while power save is on.
    always @(posedge i_clock) begin
        if (i_srst) begin
            valid_flag_q <= 1'b0;
        end else if (i_valid_frame) begin
            valid_flag_q <= 1'b1;
        end else if (ctl_wr && i_wdata[`CTL_CLR_VALID] && (ps_now == `PS_NONE)) begin
            valid_flag_q <= 1'b0;
        end
    end

    // Last error code; mode changes never touch it, only a zero write or a new error.
    // The error wins over a zero write in one cycle, so no error is lost to a
    // clear that software issued before it could have seen that error.
    // Writes with a nonzero low byte are dropped in full rather than masked to three bits.
    always @(posedge i_clock) begin
        if (i_srst) begin
            last_error_code_q <= `LEC_NONE;
        end else if (i_err_valid) begin
            last_error_code_q <= i_err_code;
        end else if (lec_wr && (i_wdata[7:0] == `LEC_CLEAR_VALUE)) begin
            last_error_code_q <= `LEC_NONE;
        end
    end

    // Transmit counter step, simplified to the main fault-confinement moves.
    // It freezes at bus-off until software clears it.
    always @* begin
        tx_next = tx_error_count_q;
        if (bus_off_flag) begin
            tx_next = tx_error_count_q;
        end else if (i_tx_error && !i_tx_primary_dominant) begin
            tx_next = tx_error_count_q + `TX_ERR_INC;
        end else if (i_tx_success && (tx_error_count_q != `TX_ZERO)) begin
            tx_next = tx_error_count_q - `TX_ERR_DEC;
        end
    end

    // Receive counter step; it saturates so an error storm cannot wrap it.
    always @* begin
        rx_next = rx_error_count_q;
        if (i_rx_error) begin
            if (i_rx_primary) begin
                rx_next = (rx_error_count_q > `RX_PRIMARY_ROOM) ? `RX_COUNT_MAX :
                    rx_error_count_q + `RX_ERR_INC_PRIMARY;
            end else if (rx_error_count_q != `RX_COUNT_MAX) begin
                rx_next = rx_error_count_q + `RX_ERR_INC_SECONDARY;
            end
        end else if (i_rx_success) begin
            if ({1'b0, rx_error_count_q} >= `PASSIVE_LIMIT) begin
                rx_next = `RX_PASSIVE_RELOAD;
            end else if (rx_error_count_q != `RX_ZERO) begin
                rx_next = rx_error_count_q - `RX_ERR_DEC;
            end
        end
    end

    // The counters clear on request; they cannot be written otherwise.
    // A request that races a mode change out of initialization is dropped.
    always @(posedge i_clock) begin
        if (i_srst) begin
            tx_error_count_q <= `TX_ZERO;
            rx_error_count_q <= `RX_ZERO;
        end else if (error_counter_clear_request_q && (op_now == `OP_INIT)) begin
            tx_error_count_q <= `TX_ZERO;
            rx_error_count_q <= `RX_ZERO;
        end else begin
            tx_error_count_q <= tx_next;
            rx_error_count_q <= rx_next;
        end
    end

    // Read mux; unmapped addresses read zero rather than alias a register.
    // Control reads back clear request, retry, valid, power save and mode
    // from bit 7 down; the upper byte is zero as set halves are write-only.
    // The information register packs bus-off over the two level fields.
    // The counter register puts the passive flag on top, then seven bits of
    // receive count, then the low byte of the transmit count.
    always @* begin
        case (i_addr)
            `ADDR_MODULE_CONTROL: read_mux = {8'h00, error_counter_clear_request_q,
                lost_arbitration_retry_q, valid_flag_q, ps_now, op_now};
            `ADDR_LAST_PROTOCOL_ERROR: read_mux = {13'h0000, last_error_code_q};
            `ADDR_ERROR_LEVEL_INFO: read_mux = {8'h00, error_level_info};
            `ADDR_ERROR_COUNTERS: read_mux = error_counters;
            default: read_mux = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_rdata <= `DATA_ZERO;
        end else if (i_rd) begin
            o_rdata <= read_mux;
        end else begin
            o_rdata <= `DATA_ZERO;
        end
    end

    // Registered copies of the mode state; they trail the registers by one cycle.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_operating_mode <= `OP_INIT;
            o_power_save <= `PS_NONE;
            o_lost_arbitration_retry <= 1'b0;
        end else begin
            o_operating_mode <= op_now;
            o_power_save <= ps_now;
            o_lost_arbitration_retry <= lost_arbitration_retry_q;
        end
    end

    // Outside single-shot the retry bit has no effect, so retry is normal.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_retry_after_loss <= 1'b0;
        end else begin
            o_retry_after_loss <= (op_now != `OP_SINGLE) || lost_arbitration_retry_q;
        end
    end

    // Bus-off is mirrored on a pin so the frame engine can stop sending.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_bus_off_flag <= 1'b0;
        end else begin
            o_bus_off_flag <= bus_off_flag;
        end
    end

endmodule // can_control_error_status

// file: logic/can_ctrl_err_map.vh
`ifndef CAN_CTRL_ERR_MAP_VH
`define CAN_CTRL_ERR_MAP_VH
`define ADDR_MODULE_CONTROL 4'h0
`define ADDR_LAST_PROTOCOL_ERROR 4'h1
`define ADDR_ERROR_LEVEL_INFO 4'h2
`define ADDR_ERROR_COUNTERS 4'h3
`define CTL_SET_CLEAR_REQ 15
`define CTL_SET_RETRY 14
`define CTL_CLR_RETRY 6
`define CTL_CLR_VALID 5
`define CTL_PS_HI 4
`define CTL_PS_LO 3
`define CTL_OP_HI 2
`define CTL_OP_LO 0
`define CTL_SET_SHIFT 8
`define OP_INIT 3'h0
`define OP_SINGLE 3'h4
`define PS_NONE 2'h0
`define PS_SLEEP 2'h1
`define PS_STOP 2'h3
`define LVL_LOW 2'h0
`define LVL_WARN 2'h1
`define LVL_PASSIVE 2'h3
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h080
`define BUSOFF_LIMIT 9'h100
`define LEC_NONE 3'h0
`define LEC_BIT_REC 3'h4
`define LEC_BIT_DOM 3'h5
`define TX_ERR_INC 9'h008
`define RX_ERR_INC_PRIMARY 8'h08
`define RX_PASSIVE_RELOAD 8'h77
`define RX_ERR_INC_SECONDARY 8'h01
`define RX_ERR_DEC 8'h01
`define RX_COUNT_MAX 8'hFF
`define RX_PRIMARY_ROOM 8'hF7
`define RX_ZERO 8'h00
`define TX_ERR_DEC 9'h001
`define TX_ZERO 9'h000
`define PAIR_SET 2'h2
`define PAIR_CLR 2'h1
`define PS_BAD 2'h2
`define LEC_CLEAR_VALUE 8'h00
`define DATA_ZERO 16'h0000
`endif

// file: verification/can_ctrl_err_sva.sv
`timescale 1ns/100ps
// Watches the register port and the mode outputs of the control block.
module can_ctrl_err_sva #(
    parameter ADDR_W = 4
) (
    input wire i_clock,
    input wire i_srst,
    input wire [ADDR_W-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    input wire [2:0] o_operating_mode,
    input wire [1:0] o_power_save,
    input wire o_lost_arbitration_retry,
    input wire o_retry_after_loss
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // Mode writes only count while no power save is active, or they are refused.
    sequence op_set_s;
        i_wr && i_addr == 4'h0 && i_wdata == 16'h0100 && o_power_save == 2'h0;
    endsequence
    sequence op_clr_s;
        i_wr && i_addr == 4'h0 && i_wdata == 16'h0001 && o_power_save == 2'h0;
    endsequence
    op_set_a: assert property (op_set_s |-> ##2 o_operating_mode[0])
        else $error("mode bit not set by set half");
    op_clear_a: assert property (op_clr_s |-> ##2 !o_operating_mode[0])
        else $error("mode bit not cleared by clear half");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside an answer");
    lec_upper_a: assert property ($past(i_rd) && $past(i_addr) == 4'h1 |-> o_rdata[15:3] == 13'h0)
        else $error("error code upper bits not zero");
    info_upper_a: assert property ($past(i_rd) && $past(i_addr) == 4'h2 |-> o_rdata[15:5] == 11'h0)
        else $error("info upper bits not zero");
    info_levels_a: assert property ($past(i_rd) && $past(i_addr) == 4'h2
        |-> o_rdata[3:2] != 2'h2 && o_rdata[1:0] != 2'h2)
        else $error("undefined error level shown");
    busoff_level_a: assert property ($past(i_rd) && $past(i_addr) == 4'h2 && o_rdata[4]
        |-> o_rdata[3:2] == 2'h3)
        else $error("bus-off without passive transmit level");
    retry_rule_a: assert property (!$past(i_srst) |-> o_retry_after_loss
        == !(o_operating_mode == 3'h4 && !o_lost_arbitration_retry))
        else $error("retry decision wrong for mode and retry bit");
    ps_legal_a: assert property (o_power_save != 2'h2)
        else $error("prohibited power save code");
    ps_via_sleep_a: assert property ((o_power_save == 2'h3 |-> $past(o_power_save) != 2'h0)
        and (o_power_save == 2'h0 |-> $past(o_power_save) != 2'h3))
        else $error("stop mode entered or left directly");
endmodule // can_ctrl_err_sva

bind can_control_error_status can_ctrl_err_sva #(.ADDR_W(ADDR_W)) u_sva (.i_clock, .i_srst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_operating_mode, .o_power_save,
    .o_lost_arbitration_retry, .o_retry_after_loss);

// file: verification/can_bus_events.sv
`timescale 1ns/100ps
// Frame engine and bus stand-in: bursts of one-cycle event pulses, one every other cycle.
module can_bus_events (
    input wire logic i_clock,
    output logic [6:0] o_ev = 7'h00,
    output logic [2:0] o_code = 3'h0
);
    // The code is inverted once released, so a stale value is never mistaken for a new one.
    task automatic send(input logic [6:0] e, input logic [2:0] c, input int n);
        repeat (n) begin
            @(posedge i_clock);
            o_ev <= e;
            o_code <= c;
            @(posedge i_clock);
            o_ev <= 7'h00;
            o_code <= ~c;
        end
    endtask
endmodule // can_bus_events

// file: verification/test_can_control_error_status.sv
`timescale 1ns/100ps
// Bench for the control and error-status registers.
module test_can_control_error_status;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] o_rdata;
    logic [2:0] o_operating_mode, code;
    logic [1:0] o_power_save;
    logic o_lost_arbitration_retry, o_retry_after_loss, o_bus_off_flag;
    logic [6:0] ev;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    // Clock at 125 MHz.
    always #4 i_clock = ~i_clock;
    // The run needs well under a thousand cycles, so this only trips on a hang.
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            wrap_up();
        end
    end
    can_bus_events u_bus (.i_clock(i_clock), .o_ev(ev), .o_code(code));
    can_control_error_status u_dut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_valid_frame(ev[5]),
        .i_err_valid(ev[6]), .i_err_code(code), .i_tx_error(ev[0]),
        .i_tx_primary_dominant(1'b0), .i_tx_success(ev[1]), .i_rx_error(ev[2]),
        .i_rx_primary(ev[3]), .i_rx_success(ev[4]), .i_lost_arbitration(1'b0),
        .o_rdata(o_rdata), .o_operating_mode(o_operating_mode), .o_power_save(o_power_save),
        .o_lost_arbitration_retry(o_lost_arbitration_retry),
        .o_retry_after_loss(o_retry_after_loss), .o_bus_off_flag(o_bus_off_flag));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string nm);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk(nm, o_rdata, exp);
    endtask
    task automatic reset_values();
        rd_chk(4'h1, 16'h0000, "lec");
        rd_chk(4'h2, 16'h0000, "info");
        rd_chk(4'h3, 16'h0000, "cnt");
    endtask
    task automatic control_pairs();
        wr(4'h0, 16'h0100);
        rd_chk(4'h0, 16'h0001, "ctl");
        wr(4'h0, 16'h0101);
        rd_chk(4'h0, 16'h0001, "ctl");
        wr(4'h0, 16'h0401);
        rd_chk(4'h0, 16'h0004, "ctl");
        chk("mode", {13'h0, o_operating_mode}, 16'h0004);
        chk("retry", {15'h0, o_retry_after_loss}, 16'h0000);
        wr(4'h0, 16'h4000);
        rd_chk(4'h0, 16'h0044, "ctl");
        chk("retry bit", {15'h0, o_lost_arbitration_retry}, 16'h0001);
        chk("retry", {15'h0, o_retry_after_loss}, 16'h0001);
        wr(4'h0, 16'h4040);
        rd_chk(4'h0, 16'h0044, "ctl");
        wr(4'h0, 16'h0040);
        wr(4'hF, 16'hFFFF);
        rd_chk(4'h0, 16'h0004, "ctl");
    endtask
    task automatic power_save_path();
        wr(4'h0, 16'h1000);
        rd_chk(4'h0, 16'h0004, "ctl");
        wr(4'h0, 16'h0800);
        wr(4'h0, 16'h0100);
        rd_chk(4'h0, 16'h000C, "ctl");
        wr(4'h0, 16'h1000);
        wr(4'h0, 16'h0018);
        rd_chk(4'h0, 16'h001C, "ctl");
        chk("ps", {14'h0, o_power_save}, 16'h0003);
        wr(4'h0, 16'h0010);
        wr(4'h0, 16'h0008);
        wr(4'h0, 16'h0004);
        rd_chk(4'h0, 16'h0000, "ctl");
    endtask
    task automatic valid_flag();
        u_bus.send(7'h20, 3'h0, 1);
        rd_chk(4'h0, 16'h0020, "ctl");
        wr(4'h0, 16'h0000);
        rd_chk(4'h0, 16'h0020, "ctl");
        wr(4'h0, 16'h0020);
        rd_chk(4'h0, 16'h0000, "ctl");
    endtask
    task automatic last_error();
        for (int c = 1; c < 8; c++) begin
            u_bus.send(7'h40, c[2:0], 1);
            rd_chk(4'h1, {13'h0, c[2:0]}, "lec");
        end
        wr(4'h1, 16'h0003);
        wr(4'h0, 16'h0100);
        wr(4'h0, 16'h0001);
        rd_chk(4'h1, 16'h0007, "lec");
        wr(4'h1, 16'h0000);
        rd_chk(4'h1, 16'h0000, "lec");
    endtask
    // Counts step through every level boundary, including 255 against 263 at bus-off.
    task automatic error_counters();
        u_bus.send(7'h01, 3'h0, 12);
        rd_chk(4'h2, 16'h0004, "info");
        rd_chk(4'h3, 16'h0060, "cnt");
        u_bus.send(7'h01, 3'h0, 4);
        u_bus.send(7'h0C, 3'h0, 12);
        rd_chk(4'h2, 16'h000D, "info");
        u_bus.send(7'h04, 3'h0, 32);
        rd_chk(4'h3, 16'h8080, "cnt");
        u_bus.send(7'h02, 3'h0, 1);
        wr(4'h3, 16'hFFFF);
        rd_chk(4'h3, 16'h807F, "cnt");
        rd_chk(4'h2, 16'h0007, "info");
        u_bus.send(7'h01, 3'h0, 16);
        rd_chk(4'h2, 16'h000F, "info");
        u_bus.send(7'h01, 3'h0, 1);
        rd_chk(4'h2, 16'h001F, "info");
        chk("bus_off_flag", {15'h0, o_bus_off_flag}, 16'h0001);
        u_bus.send(7'h10, 3'h0, 1);
        rd_chk(4'h2, 16'h001D, "info");
        wr(4'h0, 16'h8000);
        rd_chk(4'h3, 16'h0000, "cnt");
        rd_chk(4'h2, 16'h0000, "info");
        rd_chk(4'h0, 16'h0000, "ctl");
        chk("bus_off_flag", {15'h0, o_bus_off_flag}, 16'h0000);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Reset for two cycles, then run every scenario in turn.
    initial begin
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        reset_values();
        control_pairs();
        power_save_path();
        valid_flag();
        last_error();
        error_counters();
        wrap_up();
    end
endmodule // test_can_control_error_status
